// [shared/lech_regs.vh]
// Register offsets, field layout and reset values for the lane error counter hold block.
`ifndef LECH_REGS_VH
`define LECH_REGS_VH
`define LECH_ADDR_W        12
`define LECH_DATA_W        8
`define LECH_LANE3_OFS     12'h48b
`define LECH_LANE4_OFS     12'h48c
`define LECH_HOLD_MSB      2
`define LECH_HOLD_LSB      0
`define LECH_HOLD_W        3
`define LECH_HOLD_RST      3'h7
`define LECH_BIT_UNEXP_K   2
`define LECH_BIT_NOT_TABLE 1
`define LECH_BIT_DISPARITY 0
`define LECH_CNT_W         8
`define LECH_CNT_TERMINAL  8'hff
`define LECH_CNT_ZERO      8'h00
`define LECH_CNT_ONE       8'h01
`define LECH_RSVD_ZERO     5'h00
`define LECH_RDATA_ZERO    8'h00
`endif

// [src/lech_lane_err_hold.v]
// Hold-enable registers for lanes 3 and 4 and the six error counters they steer.
//
// Operation
// - Hold bit set: counter stops at 0xFF until software clears it.
// - Hold bit clear: counter wraps to zero after 0xFF.
// - Bit 2 unexpected control char, bit 1 not-in-table, bit 0 bad disparity.
// - Field is bits 2:0, read/write, resets to 0x7.
// - Lane 3 register at 0x48B, lane 4 at 0x48C, each own lane only.
`timescale 1ns/1ps
`include "lech_regs.vh"

module lech_lane_err_hold (
   // Clock and reset.
   input  wire                        clk_in,
   input  wire                        sys_rst_in,
   // Configuration port.
   input  wire [`LECH_ADDR_W-1:0]     reg_addr_in,
   input  wire                        reg_wr_in,
   input  wire                        reg_rd_in,
   input  wire [`LECH_DATA_W-1:0]     reg_wdata_in,
   output wire [`LECH_DATA_W-1:0]     reg_rdata_out,
   // Error events and counter clears; [2:0] lane 3, [5:3] lane 4.
   input  wire [5:0]                  err_event_in,
   input  wire [5:0]                  err_count_clr_in,
   // Counter values, 8 bits each, counter k at [8k+7:8k].
   output wire [6*`LECH_CNT_W-1:0]    err_count_out,
   // Hold-enable fields as seen by the lane decoder.
   output wire [`LECH_HOLD_W-1:0]     lane3_err_count_hold_out,
   output wire [`LECH_HOLD_W-1:0]     lane4_err_count_hold_out
);

   // Hold-enable storage.
   reg  [`LECH_HOLD_W-1:0]  lane3_err_count_hold_ff;
   reg  [`LECH_HOLD_W-1:0]  lane4_err_count_hold_ff;
   reg  [`LECH_HOLD_W-1:0]  nxt_lane3_err_count_hold;
   reg  [`LECH_HOLD_W-1:0]  nxt_lane4_err_count_hold;

   // Read data storage.
   reg  [`LECH_DATA_W-1:0]  rdata_ff;
   reg  [`LECH_DATA_W-1:0]  nxt_rdata;

   // Address decode.
   wire                     lane3_hit;
   wire                     lane4_hit;
   wire                     lane3_wr;
   wire                     lane4_wr;
   wire                     lane3_rd;
   wire                     lane4_rd;
   wire                     unmapped_rd;

   // Field views of the bus data.
   wire [`LECH_HOLD_W-1:0]  wr_field;
   wire [`LECH_DATA_W-1:0]  lane3_rd_word;
   wire [`LECH_DATA_W-1:0]  lane4_rd_word;

   // Hold bits of all six counters, lane 3 in the low half.
   wire [5:0]               hold_all;

   assign lane3_hit   = (reg_addr_in == `LECH_LANE3_OFS);
   assign lane4_hit   = (reg_addr_in == `LECH_LANE4_OFS);
   assign lane3_wr    = reg_wr_in & lane3_hit;
   assign lane4_wr    = reg_wr_in & lane4_hit;
   assign lane3_rd    = reg_rd_in & lane3_hit;
   assign lane4_rd    = reg_rd_in & lane4_hit;
   assign unmapped_rd = reg_rd_in & ~lane3_hit & ~lane4_hit;

   // Only the field bits are kept; bits 7:3 have no storage.
   assign wr_field = reg_wdata_in[`LECH_HOLD_MSB:`LECH_HOLD_LSB];

   // Reserved bits read back as zero.
   assign lane3_rd_word = {`LECH_RSVD_ZERO, lane3_err_count_hold_ff};
   assign lane4_rd_word = {`LECH_RSVD_ZERO, lane4_err_count_hold_ff};

   // Writes are not gated by the decoder soft reset; that ordering is left to software.
   always @* begin
      nxt_lane3_err_count_hold = lane3_err_count_hold_ff;
      if (lane3_wr) begin
         nxt_lane3_err_count_hold = wr_field;
      end
   end

   always @* begin
      nxt_lane4_err_count_hold = lane4_err_count_hold_ff;
      if (lane4_wr) begin
         nxt_lane4_err_count_hold = wr_field;
      end
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         lane3_err_count_hold_ff <= `LECH_HOLD_RST;
      end else begin
         lane3_err_count_hold_ff <= nxt_lane3_err_count_hold;
      end
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         lane4_err_count_hold_ff <= `LECH_HOLD_RST;
      end else begin
         lane4_err_count_hold_ff <= nxt_lane4_err_count_hold;
      end
   end

   // Read data is registered and holds until the next read; unmapped reads return zero.
   always @* begin
      nxt_rdata = rdata_ff;
      if (lane3_rd) begin
         nxt_rdata = lane3_rd_word;
      end
      if (lane4_rd) begin
         nxt_rdata = lane4_rd_word;
      end
      if (unmapped_rd) begin
         nxt_rdata = `LECH_RDATA_ZERO;
      end
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_ff <= `LECH_RDATA_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // Counter k uses hold bit k; bit order within a lane follows the error type.
   assign hold_all = {lane4_err_count_hold_ff, lane3_err_count_hold_ff};

   genvar k;
   generate
      for (k = 0; k < 6; k = k + 1) begin : g_cnt
         reg  [`LECH_CNT_W-1:0] cnt_ff;
         reg  [`LECH_CNT_W-1:0] nxt_cnt;
         wire                   ev;
         wire                   clr;
         wire                   hold;
         wire                   at_top;
         wire [`LECH_CNT_W-1:0] base;
         wire [`LECH_CNT_W-1:0] stepped;
         wire [`LECH_CNT_W-1:0] rolled;

         assign ev      = err_event_in[k];
         assign clr     = err_count_clr_in[k];
         assign hold    = hold_all[k];

         // A clear together with an event leaves the counter at one.
         assign base    = clr ? `LECH_CNT_ZERO : cnt_ff;
         assign at_top  = (base == `LECH_CNT_TERMINAL);
         assign stepped = base + `LECH_CNT_ONE;
         assign rolled  = hold ? `LECH_CNT_TERMINAL : `LECH_CNT_ZERO;

         always @* begin
            nxt_cnt = base;
            if (ev) begin
               if (at_top) begin
                  nxt_cnt = rolled;
               end else begin
                  nxt_cnt = stepped;
               end
            end
         end

         always @(posedge clk_in) begin
            if (sys_rst_in) begin
               cnt_ff <= `LECH_CNT_ZERO;
            end else begin
               cnt_ff <= nxt_cnt;
            end
         end

         assign err_count_out[k*`LECH_CNT_W +: `LECH_CNT_W] = cnt_ff;
      end
   endgenerate

   assign reg_rdata_out            = rdata_ff;
   assign lane3_err_count_hold_out = lane3_err_count_hold_ff;
   assign lane4_err_count_hold_out = lane4_err_count_hold_ff;

endmodule // lech_lane_err_hold

// [testbench/lech_assertions.sv]
// Lane error hold checker.
`timescale 1ns/1ps
module lech_chk (input wire clk_in, sys_rst_in, reg_wr_in, reg_rd_in,
   input wire [11:0] reg_addr_in, input wire [7:0] reg_wdata_in, reg_rdata_out,
   input wire [5:0] err_event_in, err_count_clr_in, input wire [47:0] err_count_out,
   input wire [2:0] lane3_err_count_hold_out, lane4_err_count_hold_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire [2:0] h = lane3_err_count_hold_out;
   wire [7:0] c0 = err_count_out[7:0], c1 = err_count_out[15:8], c2 = err_count_out[23:16];
   wire a = reg_addr_in == 12'h48b, b = reg_addr_in == 12'h48c;
   wire u = err_event_in[2] && !err_count_clr_in[2] && c2 != 8'hff;
   wire t0 = err_event_in[0] && !err_count_clr_in[0] && c0 == 8'hff && h[0];
   wire t1 = err_event_in[1] && !err_count_clr_in[1] && c1 == 8'hff && !h[1];
   chk_lane4_write: assert property (reg_wr_in && b |=> lane4_err_count_hold_out == $past(reg_wdata_in[2:0]))
      else $error("lost4");
   chk_lane3_write: assert property (reg_wr_in && a |=> h == $past(reg_wdata_in[2:0]))
      else $error("lost");
   chk_lane_alone: assert property (reg_wr_in && !a |=> $stable(h)) else $error("moved");
   chk_read_back: assert property (reg_rd_in && a |=> reg_rdata_out == {5'h00, $past(h)})
      else $error("read");
   chk_hold_top: assert property (t0 |=> c0 == 8'hff) else $error("hold");
   chk_wrap_zero: assert property (t1 |=> c1 == 8'h00) else $error("wrap");
   chk_count_step: assert property (u |=> c2 == $past(c2) + 8'h01) else $error("step");
   cover property (reg_wr_in && a);
   cover property (t0);
   cover property (t1);
endmodule // lech_chk
bind lech_lane_err_hold lech_chk chk_u (.*);

// [testbench/lech_lane_err_hold_tb_top.sv]
// Hold register bench.
`timescale 1ns/1ps
module lech_lane_err_hold_tb_top;
   reg clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
   reg [11:0] reg_addr_in = 0;
   reg [7:0] reg_wdata_in = 0;
   reg [5:0] err_event_in = 0, err_count_clr_in = 0;
   wire [7:0] reg_rdata_out;
   wire [47:0] err_count_out;
   wire [2:0] lane3_err_count_hold_out, lane4_err_count_hold_out;
   integer n_mismatch = 0, tests_run = 0, i;
   lech_lane_err_hold dut_u (.*);
   initial forever #50 clk_in = ~clk_in;
   initial begin repeat (2000) @(posedge clk_in); n_mismatch++; complete_run; end
   task complete_run;
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input [7:0] s, e);
      tests_run++;
      if (s !== e) begin n_mismatch++; $display("BAD %0t %h %h", $time, s, e); end
   endtask
   task acc(input w, input [11:0] a, input [7:0] v);
      {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} <= {a, v, w, !w};
      @(posedge clk_in) {reg_wr_in, reg_rd_in} <= 0;
      @(posedge clk_in) if (!w) chk(reg_rdata_out, v);
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 0;
      acc(0, 12'h48b, 8'h07); acc(1, 12'h48b, 8'hf9); acc(1, 12'h48c, 8'h06);
      chk(lane3_err_count_hold_out, 8'h01); chk(lane4_err_count_hold_out, 8'h06);
      acc(0, 12'h48b, 8'h01); acc(0, 12'h48c, 8'h06); acc(0, 12'h48d, 8'h00);
      for (i = 0; i < 6; i++) begin
         err_event_in <= 6'h01 << i;
         repeat (256) @(posedge clk_in);
         err_event_in <= 0;
         @(posedge clk_in) chk(err_count_out[8*i+:8], 6'h31 >> i & 1 ? 8'hff : 8'h00);
      end
      err_count_clr_in <= 6'h01;
      @(posedge clk_in) err_count_clr_in <= 0;
      @(posedge clk_in) chk(err_count_out[7:0], 8'h00);
      {err_count_clr_in, err_event_in} <= {6'h01, 6'h01};
      @(posedge clk_in) {err_count_clr_in, err_event_in} <= 0;
      @(posedge clk_in) chk(err_count_out[7:0], 8'h01);
      sys_rst_in <= 1;
      @(posedge clk_in) sys_rst_in <= 0;
      @(posedge clk_in) chk(lane3_err_count_hold_out, 8'h07);
      chk(err_count_out[7:0], 8'h00);
      acc(0, 12'h48c, 8'h07);
      complete_run;
   end
endmodule // lech_lane_err_hold_tb_top
